// ===== common/pgc_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from design files
`ifndef PGC_MAP_SVH
`define PGC_MAP_SVH
`define PGC_IDX_MAIN      2'h0
`define PGC_IDX_CALIB     2'h1
`define PGC_IDX_TIMING    2'h2
`define PGC_IDX_STATUS    2'h3
`define PGC_MAIN_RST      8'h00
`define PGC_CALIB_RST     8'h02
`define PGC_TIMING_RST    8'h0c
`define PGC_BIT_EN        0
`define PGC_BIT_LP        1
`define PGC_BIT_TM        7
`define PGC_BIT_SOFT_TRIGGER    5
`define PGC_BIT_BYPASS    5
`define PGC_STARTUP_CLKS  5'h10
`define PGC_CAL_OFFSET    2'h2
`endif

// ===== common/pgc_pkg.sv
// Types shared by the amplifier control logic
// Assumes no other package
`default_nettype none
package pgc_pkg;
  typedef enum logic [3:0] {
    PGC_OFF   = 4'h1,
    PGC_START = 4'h2,
    PGC_IDLE  = 4'h4,
    PGC_RUN   = 4'h8
  } pgc_state_t;
endpackage : pgc_pkg
`default_nettype wire

// ===== rtl/pgc_top.sv
// Amplifier control and status logic with an AXI4-Lite register slave
// Assumes trigger inputs from a foreign domain; one clock, aclk at 200 MHz
//
// The AXI4-Lite register port was left to the implementer.
`include "pgc_map.svh"
`default_nettype none
// Operation
// RULE1: Trigger mode bit chooses software trigger or hardware rising edge start.
// RULE2: Gain code splits into hold, differential and single-ended stage selects.
// RULE3: Overall gain is the product of the three stage gains, 1x to 32x.
// RULE4: Enable powers the amplifier; clear powers down and grounds output.
// RULE5: Power level bit selects low or high power; shared bias kept when any high.
// RULE6: Calibration mode 00 normal, 10 offset calibration, others reserved.
// RULE7: Software writes zero to the hold bypass bit.
// RULE8: Pump clock is oscillator divided by two to the divisor; reset 2.
// RULE9: Soft trigger write starts a conversion in software mode; reads zero.
// RULE10: Software sets gain stage clock count to at least one for soft triggers.
// RULE11: Gain stages are clocked count plus one times per conversion.
// RULE12: Clock divide field divides input clock by 1, 2, 4 or 8.
// RULE13: Running flag shows an active conversion, resynchronised to the bus.
// RULE14: Startup done reads one only when enabled and startup has finished.
// RULE15: Reset makes the amplifier inactive and restores all register defaults.
// RULE16: The block drives no interrupt request.
// RULE17: Runs in run and wait; in stop only when stop disable is set.
// RULE18: Clock supplier keeps clocks at or below 1 MHz in low power modes.
// RULE19: Software clears enable before partial power down.
// RULE20: Registers sit at consecutive words; bits above seven read zero.
// RULE21: After enable, sample ground for 16 amplifier clocks, then startup done.
// RULE22: Disabled passes triggers unchanged; enabled hardware mode issues new ones.
// RULE23: Each accepted trigger sets running, clocks the stages, triggers, clears.
module pgc_top
  import pgc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_clk_en,
  input  wire logic        stop_mode,
  input  wire logic        stop_disable,
  input  wire logic        other_amp_high_power,
  input  wire logic        hw_trigger_in,
  input  wire logic        hw_pretrigger_in,
  output logic             conv_trigger_out,
  output logic             conv_pretrigger_out,
  output logic             amp_enable,
  output logic             amp_high_power,
  output logic             shared_bias_on,
  output logic             output_grounded,
  output logic             sample_ground,
  output logic             hold_bypass,
  output logic             hold_gain_x2,
  output logic [1:0]       diff_gain_sel,
  output logic [1:0]       dse_gain_sel,
  output logic [5:0]       total_gain,
  output logic             pump_clk_en,
  output logic             amp_clk_en,
  output logic             stage_clk,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] main_reg;
  logic [7:0] calib_reg;
  logic [4:0] timing_reg;
  logic       aw_held_reg;
  logic       w_held_reg;
  logic [1:0] aw_idx_reg;
  logic [7:0] wdata_reg;
  logic       wstrb0_reg;
  logic       soft_pulse_reg;
  logic       running_meta_reg;
  logic       running_sync_reg;
  logic       startup_done_reg;
  logic       do_write;
  logic       active;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_held_reg & w_held_reg;
  assign irq           = 1'b0; // [RULE16]

  // Address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 2'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg  <= s_axi_awaddr[3:2];
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register stores; defaults restored by reset [RULE15]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_reg   <= `PGC_MAIN_RST;
      calib_reg  <= `PGC_CALIB_RST;
      timing_reg <= 5'(`PGC_TIMING_RST);
    end else if (do_write && wstrb0_reg) begin
      unique case (aw_idx_reg)
        `PGC_IDX_MAIN:   main_reg   <= wdata_reg;
        `PGC_IDX_CALIB:  calib_reg  <= {2'h0, wdata_reg[5:0]};
        `PGC_IDX_TIMING: timing_reg <= wdata_reg[4:0];
        default: ;
      endcase
    end
  end

  // Soft trigger holds no state [RULE9]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_pulse_reg <= 1'b0;
    end else begin
      soft_pulse_reg <= do_write && wstrb0_reg && aw_idx_reg == `PGC_IDX_TIMING
                        && wdata_reg[`PGC_BIT_SOFT_TRIGGER] && main_reg[`PGC_BIT_TM];
    end
  end

  // Reads; upper bits zero [RULE20]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr[3:2])
        `PGC_IDX_MAIN:   s_axi_rdata <= {24'h000000, main_reg};
        `PGC_IDX_CALIB:  s_axi_rdata <= {24'h000000, calib_reg};
        `PGC_IDX_TIMING: s_axi_rdata <= {27'h0000000, timing_reg};
        `PGC_IDX_STATUS: s_axi_rdata <= {30'h00000000, running_sync_reg,
                                         startup_done_reg}; // [RULE13] [RULE14]
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Static controls
  assign active         = ~(stop_mode & ~stop_disable); // [RULE17]
  assign amp_enable     = main_reg[`PGC_BIT_EN] & active; // [RULE4]
  assign output_grounded = ~amp_enable; // [RULE4]
  assign amp_high_power = main_reg[`PGC_BIT_LP]; // [RULE5]
  assign shared_bias_on = (amp_enable & amp_high_power) | other_amp_high_power; // [RULE5]
  assign hold_bypass    = calib_reg[`PGC_BIT_BYPASS];
  assign hold_gain_x2   = main_reg[2]; // [RULE2]
  assign diff_gain_sel  = main_reg[4:3]; // [RULE2]
  assign dse_gain_sel   = main_reg[6:5]; // [RULE2]
  // Gain product [RULE3]
  assign total_gain = 6'({5'h00, hold_gain_x2} + 6'h01)
                      * 6'({4'h0, diff_gain_sel} + 6'h01)
                      * 6'({4'h0, dse_gain_sel} + 6'h01);

  ////////////////////////////////////////////////////////////////////////
  // Clock enables
  logic [6:0] pump_cnt_reg;
  logic [2:0] amp_clock_divide_cnt_reg;
  logic [2:0] amp_clock_divide_max;

  // Oscillator tick counter for the pump divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_cnt_reg <= 7'h00;
    end else if (osc_clk_en) begin
      pump_cnt_reg <= pump_cnt_reg + 7'h01;
    end
  end
  // Divide oscillator by 2^divisor [RULE8]
  assign pump_clk_en = osc_clk_en & amp_enable
                       & ((pump_cnt_reg & 7'((8'h01 << calib_reg[2:0]) - 8'h01)) == 7'h00);

  function automatic logic [1:0] main_amp_clock_divide();
    return timing_reg[1:0];
  endfunction : main_amp_clock_divide
  assign amp_clock_divide_max = 3'((4'h1 << main_amp_clock_divide()) - 4'h1);

  // Amplifier clock divide 1/2/4/8 [RULE12]
  always_ff @(posedge aclk) begin
    if (!aresetn || !amp_enable) begin
      amp_clock_divide_cnt_reg <= 3'h0;
    end else if (amp_clock_divide_cnt_reg >= amp_clock_divide_max) begin
      amp_clock_divide_cnt_reg <= 3'h0;
    end else begin
      amp_clock_divide_cnt_reg <= amp_clock_divide_cnt_reg + 3'h1;
    end
  end
  assign amp_clk_en = amp_enable & (amp_clock_divide_cnt_reg >= amp_clock_divide_max);

  ////////////////////////////////////////////////////////////////////////
  // Trigger input synchronisers
  logic [2:0] trig_sync_reg;
  logic [2:0] pre_sync_reg;
  logic       trig_level_reg;
  logic       pre_level_reg;
  logic       trig_prev_reg;
  logic       hw_edge;

  // Trigger pin: level moves once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sync_reg  <= 3'h0;
      trig_level_reg <= 1'b0;
      trig_prev_reg  <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], hw_trigger_in};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_level_reg <= trig_sync_reg[2];
      end
      trig_prev_reg <= trig_level_reg;
    end
  end
  assign hw_edge = trig_level_reg & ~trig_prev_reg; // [RULE1]

  // Pretrigger pin: same filter as the trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_sync_reg  <= 3'h0;
      pre_level_reg <= 1'b0;
    end else begin
      pre_sync_reg <= {pre_sync_reg[1:0], hw_pretrigger_in};
      if (pre_sync_reg[1] == pre_sync_reg[2]) begin
        pre_level_reg <= pre_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  pgc_state_t state_reg;
  logic [4:0] start_cnt_reg;
  logic [2:0] gs_cnt_reg;
  logic       issue_reg;
  logic       start_req;

  // Start source select [RULE1]
  assign start_req = main_reg[`PGC_BIT_TM] ? soft_pulse_reg : hw_edge;

  // Sequencer held off while disabled or in reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !amp_enable) begin // [RULE15]
      state_reg     <= PGC_OFF;
      start_cnt_reg <= 5'h00;
      gs_cnt_reg    <= 3'h0;
      issue_reg     <= 1'b0;
    end else begin
      issue_reg <= 1'b0;
      unique case (state_reg)
        PGC_OFF: begin
          state_reg     <= PGC_START;
          start_cnt_reg <= 5'h00;
        end
        PGC_START: begin
          if (amp_clk_en) begin
            if (start_cnt_reg == `PGC_STARTUP_CLKS - 5'h01) begin
              state_reg <= PGC_IDLE; // [RULE21]
            end
            start_cnt_reg <= start_cnt_reg + 5'h01;
          end
        end
        PGC_IDLE: begin
          if (start_req) begin
            state_reg  <= PGC_RUN; // [RULE23]
            gs_cnt_reg <= 3'h0;
          end
        end
        PGC_RUN: begin
          if (amp_clk_en) begin
            if (gs_cnt_reg == timing_reg[4:2]) begin // [RULE11]
              state_reg <= PGC_IDLE;
              issue_reg <= 1'b1; // [RULE23]
            end else begin
              gs_cnt_reg <= gs_cnt_reg + 3'h1;
            end
          end
        end
      endcase
    end
  end

  assign stage_clk     = (state_reg == PGC_RUN) & amp_clk_en; // [RULE11]
  assign sample_ground = (state_reg == PGC_START)
                         | (calib_reg[4:3] == `PGC_CAL_OFFSET); // [RULE6] [RULE21]

  // Running flag carried through two stages toward the bus side [RULE13]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_meta_reg <= 1'b0;
      running_sync_reg <= 1'b0;
    end else begin
      running_meta_reg <= (state_reg == PGC_RUN);
      running_sync_reg <= running_meta_reg;
    end
  end

  // Startup done only while enabled and past the startup count [RULE14]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_done_reg <= 1'b0;
    end else begin
      startup_done_reg <= amp_enable & (state_reg == PGC_IDLE || state_reg == PGC_RUN);
    end
  end

  // Trigger routing toward the converter [RULE22]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_trigger_out <= 1'b0;
    end else if (!amp_enable) begin
      conv_trigger_out <= trig_level_reg;
    end else begin
      conv_trigger_out <= issue_reg;
    end
  end

  // Pretrigger passed through when disabled, reissued when enabled [RULE22]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_pretrigger_out <= 1'b0;
    end else if (!amp_enable) begin
      conv_pretrigger_out <= pre_level_reg;
    end else begin
      conv_pretrigger_out <= issue_reg;
    end
  end

endmodule : pgc_top
`default_nettype wire

// ===== tb/pgc_monitor.sv
// Concurrent checks on the amplifier control block ports
// Assumes a bind onto pgc_top with matching port names
`default_nettype none
module pgc_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stop_mode,
  input wire logic        stop_disable,
  input wire logic        other_amp_high_power,
  input wire logic        conv_trigger_out,
  input wire logic        amp_enable,
  input wire logic        amp_high_power,
  input wire logic        shared_bias_on,
  input wire logic        output_grounded,
  input wire logic        hold_gain_x2,
  input wire logic [1:0]  diff_gain_sel,
  input wire logic [1:0]  dse_gain_sel,
  input wire logic [5:0]  total_gain,
  input wire logic        pump_clk_en,
  input wire logic        amp_clk_en,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_irq; !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq raised");
  property p_gain; total_gain == ({5'h0, hold_gain_x2} + 6'h1) *
    ({4'h0, diff_gain_sel} + 6'h1) * ({4'h0, dse_gain_sel} + 6'h1); endproperty
  a_gain: assert property (p_gain) else $error("gain product");
  property p_gnd; !amp_enable |-> output_grounded && !pump_clk_en; endproperty
  a_gnd: assert property (p_gnd) else $error("disabled not grounded");
  property p_bias;
    (amp_enable && amp_high_power) || other_amp_high_power |-> shared_bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("bias off");
  property p_stop; (stop_mode && !stop_disable) [*2] |-> !amp_clk_en; endproperty
  a_stop: assert property (p_stop) else $error("clock in stop");
  property p_pulse;
    $past(amp_enable) && amp_enable && conv_trigger_out |=> !conv_trigger_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger not a pulse");
  property p_rst; disable iff (1'b0)
    !aresetn |=> !amp_enable && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  c_conv: cover property (amp_enable && conv_trigger_out);
  c_max: cover property (total_gain == 6'h20);
  c_stop: cover property (stop_mode && !stop_disable);
endmodule : pgc_monitor
`default_nettype wire

// ===== tb/pgc_partner.sv
// Trigger source and converter stand-in on the far side
// Assumes go is a one-cycle request from the bench
`default_nettype none
module pgc_partner (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [3:0] hold_len,
  input  wire logic       conv_trigger_out,
  input  wire logic       conv_pretrigger_out,
  output logic            hw_trigger_in,
  output logic            hw_pretrigger_in,
  output logic [7:0]      trig_seen,
  output logic [7:0]      pre_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] t = 5'h1f;
  logic [1:0] last = 2'h0;
  initial trig_seen = 8'h00;
  initial pre_seen = 8'h00;
  // Pretrigger leads trigger by a cycle, both low when idle
  assign hw_pretrigger_in = t < {1'b0, hold_len};
  assign hw_trigger_in = t > 5'h0 && t <= {1'b0, hold_len};
  always @(posedge aclk) begin
    t <= go ? 5'h0 : t + {4'h0, t != 5'h1f};
    last <= {conv_trigger_out, conv_pretrigger_out};
    if (conv_trigger_out && !last[1]) trig_seen <= trig_seen + 8'h1;
    if (conv_pretrigger_out && !last[0]) pre_seen <= pre_seen + 8'h1;
  end
endmodule : pgc_partner
`default_nettype wire

// ===== tb/pgc_top_test.sv
// Self-checking bench: register model, triggers and conversions
// Assumes pgc_top, pgc_partner and pgc_monitor are compiled first
`default_nettype none
module pgc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, osc_clk_en, stop_mode, stop_disable, other_amp_high_power;
  logic        hw_trigger_in, hw_pretrigger_in, conv_trigger_out, conv_pretrigger_out;
  logic        amp_enable, amp_high_power, shared_bias_on, output_grounded, sample_ground;
  logic        hold_bypass, hold_gain_x2, pump_clk_en, amp_clk_en, stage_clk, irq, go;
  logic [1:0]  s_axi_bresp, s_axi_rresp, diff_gain_sel, dse_gain_sel;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, hold_len;
  logic [5:0]  total_gain;
  logic [7:0]  trig_seen, pre_seen;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  int          mismatches, check_count, cyc, sc, pc, n, m, t0;
  int          seed = 29;
  int          mdl [3];
  pgc_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .osc_clk_en(osc_clk_en), .stop_mode(stop_mode),
    .stop_disable(stop_disable), .other_amp_high_power(other_amp_high_power),
    .hw_trigger_in(hw_trigger_in), .hw_pretrigger_in(hw_pretrigger_in),
    .conv_trigger_out(conv_trigger_out), .conv_pretrigger_out(conv_pretrigger_out),
    .amp_enable(amp_enable), .amp_high_power(amp_high_power), .shared_bias_on(shared_bias_on),
    .output_grounded(output_grounded), .sample_ground(sample_ground),
    .hold_bypass(hold_bypass), .hold_gain_x2(hold_gain_x2), .diff_gain_sel(diff_gain_sel),
    .dse_gain_sel(dse_gain_sel), .total_gain(total_gain), .pump_clk_en(pump_clk_en),
    .amp_clk_en(amp_clk_en), .stage_clk(stage_clk), .irq(irq)
  );
  pgc_partner i_far (
    .aclk(aclk), .go(go), .hold_len(hold_len), .conv_trigger_out(conv_trigger_out),
    .conv_pretrigger_out(conv_pretrigger_out), .hw_trigger_in(hw_trigger_in),
    .hw_pretrigger_in(hw_pretrigger_in), .trig_seen(trig_seen), .pre_seen(pre_seen)
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sc <= sc + int'(stage_clk);
    pc <= pc + int'(pump_clk_en);
    osc_clk_en <= cyc[1:0] == 2'h0; // Steady slow oscillator tick
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw;
    @(posedge aclk);
    {ta, tw} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ta |= s_axi_awready === 1'b1;
      tw |= s_axi_wready === 1'b1;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk(32'(s_axi_bresp), 32'h0);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rv = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'h0);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wm(input int i, input logic [7:0] v);
    wr(4'(i * 4), {24'h0, v}, 4'hf);
    mdl[i] = v & (i == 0 ? 8'hff : i == 1 ? 8'h3f : 8'h1f);
  endtask : wm
  task automatic cm(input int i);
    rd(4'(i * 4));
    chk(rv, mdl[i]);
  endtask : cm
  task automatic fire;
    @(posedge aclk);
    hold_len <= 4'(4 + $unsigned($random(seed)) % 8);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (80) @(posedge aclk);
  endtask : fire
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    {go, stop_mode, stop_disable, other_amp_high_power} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    hold_len = 4'h4;
    // Second pass resets with the amplifier already disabled
    for (int p = 0; p < 2; p++) begin
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      mdl = '{0, 2, 12};
      for (int i = 0; i < 3; i++) cm(i);
      rd(4'hc);
      chk(rv, 32'h0);
      wm(1, 8'hdf);
      chk(32'(hold_bypass), 32'h0);
      wr(4'h4, 32'hffff_ff00, 4'he);
      cm(1);
      wm(2, 8'hff);
      cm(2);
      for (int g = 0; g < 32; g++) begin
        n = $random(seed);
        other_amp_high_power <= n[1];
        wm(0, {1'b0, 5'(g), n[0], 1'b0});
        chk(32'(total_gain), (g % 2 + 1) * (g / 2 % 4 + 1) * (g / 8 + 1));
        chk(32'({dse_gain_sel, diff_gain_sel, hold_gain_x2}), g);
      end
      n = {trig_seen, pre_seen};
      fire();
      chk({trig_seen, pre_seen} - n[15:0], 32'h101);
      for (int d = 0; d < 4; d++) begin
        wm(0, 8'h00);
        wm(2, 8'h0c | 8'(d));
        wm(0, 8'h01);
        t0 = cyc;
        rd(4'hc);
        chk(rv, 32'h0);
        do rd(4'hc); while (rv[0] !== 1'b1);
        chk(32'(cyc - t0 >= (15 << d) && cyc - t0 <= (16 << d) + 12), 1);
        n = sc;
        m = trig_seen;
        fire();
        chk(sc - n, 4);
        chk(trig_seen - m, 1);
      end
      wm(0, 8'h81);
      m = trig_seen;
      fire();
      chk(trig_seen - m, 0);
      n = sc;
      wm(2, 8'h3f);
      repeat (8) @(posedge aclk);
      rd(4'hc);
      chk(rv, 32'h3);
      repeat (90) @(posedge aclk);
      rd(4'hc);
      chk(rv, 32'h1);
      chk(trig_seen - m, 1);
      chk(sc - n, 8);
      cm(2);
      for (int c = 0; c < 4; c++) begin
        wm(1, 8'(c << 3) | 8'h02);
        chk(32'(sample_ground), c == 2);
      end
      n = pc;
      repeat (64) @(posedge aclk);
      chk(pc - n, 4);
      stop_mode <= 1'b1;
      n = sc;
      wm(2, 8'h3f);
      repeat (100) @(posedge aclk);
      chk(sc - n, 0);
      stop_disable <= 1'b1;
      @(posedge aclk);
      chk(32'(amp_enable), 1);
      {stop_mode, stop_disable} <= 2'b00;
      wm(0, 8'h00);
    end
    end_of_test();
  end
endmodule : pgc_top_test
bind pgc_top pgc_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .stop_mode(stop_mode), .stop_disable(stop_disable),
  .other_amp_high_power(other_amp_high_power), .conv_trigger_out(conv_trigger_out),
  .amp_enable(amp_enable), .amp_high_power(amp_high_power), .shared_bias_on(shared_bias_on),
  .output_grounded(output_grounded), .hold_gain_x2(hold_gain_x2),
  .diff_gain_sel(diff_gain_sel), .dse_gain_sel(dse_gain_sel), .total_gain(total_gain),
  .pump_clk_en(pump_clk_en), .amp_clk_en(amp_clk_en), .irq(irq)
);
`default_nettype wire
